/* File: logic/nv_ctrl_defines.svh */
// Constants for the host-side store/recall controller of a byte-wide nonvolatile SRAM.
// Assumes a 40 MHz system clock and a 13-bit device address.
`ifndef NV_CTRL_DEFINES_SVH
`define NV_CTRL_DEFINES_SVH

// ---------------------------------------------------------------
// Unlock sequence addresses
// ---------------------------------------------------------------
`define NV_SEQ_A1 13'h0000
`define NV_SEQ_A2 13'h1555
`define NV_SEQ_A3 13'h0aaa
`define NV_SEQ_A4 13'h1fff
`define NV_SEQ_A5 13'h10f0
`define NV_SEQ_STORE 13'h0f0f
`define NV_SEQ_RECALL 13'h0f0e

// ---------------------------------------------------------------
// Timing, in nanoseconds and in 25 ns clock cycles
// ---------------------------------------------------------------
`define NV_CLK_NS 25
// Chip-enable low time per unlock read, nanoseconds.
`define NV_CE_LOW_NS 50
`define NV_CE_LOW_CYC ((`NV_CE_LOW_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
// Chip-enable high time between reads, nanoseconds.
`define NV_CE_HIGH_NS 50
`define NV_CE_HIGH_CYC ((`NV_CE_HIGH_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
// Store cycle time, nanoseconds (10 ms).
`define NV_STORE_NS 10000000
`define NV_STORE_CYC ((`NV_STORE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
// Software recall cycle time, nanoseconds (20 us).
`define NV_RECALL_NS 20000
`define NV_RECALL_CYC ((`NV_RECALL_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)
// Power-up recall duration, nanoseconds (650 us).
`define NV_RESTORE_NS 650000
`define NV_RESTORE_CYC ((`NV_RESTORE_NS + `NV_CLK_NS - 1) / `NV_CLK_NS)

`endif

/* File: logic/nv_ctrl_pkg.sv */
// Types shared by the nonvolatile SRAM store/recall controller.
// Assumes nothing beyond the defines header.
package nv_ctrl_pkg;

   // ---------------------------------------------------------------
   // Controller states, Gray coded along the usual path except ST_CE_LOW to ST_WAIT
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE = 3'h0,
      ST_CE_LOW = 3'h1,
      ST_CE_HIGH = 3'h3,
      ST_WAIT = 3'h2,
      ST_PWRUP = 3'h6
   } nv_state_e;

   // Strobes and address driven to the memory, all active-low strobes.
   typedef struct packed {
      logic ce_n;
      logic oe_n;
      logic we_n;
      logic [12:0] addr;
   } mem_pins_s;

endpackage : nv_ctrl_pkg

/* File: logic/nv_sync.sv */
// Three-stage input synchroniser with agreement filter.
// Assumes the input comes from outside the clk_sys_in domain.
`timescale 1ns/1ps
module nv_sync (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic async_in,
   input wire logic init_in,
   output logic level_out
);

   // ---------------------------------------------------------------
   // Synchroniser chain and filtered level
   // ---------------------------------------------------------------
   logic s1_q;   // First stage, read only by the second.
   logic s2_q;   // Second stage.
   logic s3_q;   // Third stage.
   logic lvl_q;  // Accepted level.
   wire agree = (s2_q == s3_q);

   // The level changes only once stages two and three agree.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         s1_q <= 1'b0;
         s2_q <= 1'b0;
         s3_q <= 1'b0;
         lvl_q <= 1'b0;
      end else begin
         s1_q <= async_in;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= agree ? s3_q : lvl_q;
      end
   end

   // Unused init kept low in all uses; level comes from flops.
   assign level_out = lvl_q | (init_in & 1'b0);

endmodule : nv_sync

/* File: logic/nv_host_ctrl.sv */
// Host-side controller that issues software store and recall to a nonvolatile SRAM.
// Assumes the memory sits on the pins below and that supply sensing arrives as a pin.
//
// How it works
// - Host keeps write strobe high at recall end.
// - Store reads 0000,?,?,1FFF,10F0 in order.
// - Host never interleaves other accesses.
// - Sequence is reads only, output enable free.
// - Recall reads end at 0F0E.
// - Each step is a chip-enable read.
// - Write strobe high while chip enabled.
`timescale 1ns/1ps
`include "nv_ctrl_defines.svh"
module nv_host_ctrl
   import nv_ctrl_pkg::*;
#(
   parameter int unsigned STORE_CYC = `NV_STORE_CYC,
   parameter int unsigned RECALL_CYC = `NV_RECALL_CYC,
   parameter int unsigned RESTORE_CYC = `NV_RESTORE_CYC
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic store_req_in,
   input wire logic recall_req_in,
   input wire logic supply_ok_in,
   output logic busy_out,
   output logic done_out,
   output logic refused_out,
   output logic mem_ce_n_out,
   output logic mem_oe_n_out,
   output logic mem_we_n_out,
   output logic [12:0] mem_addr_out
);

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   localparam int unsigned CNT_W = 24;
   initial begin
      if (STORE_CYC < 1 || RECALL_CYC < 1 || RESTORE_CYC < 1 ||
          STORE_CYC >= (1 << CNT_W) || RECALL_CYC >= (1 << CNT_W) ||
          RESTORE_CYC >= (1 << CNT_W)) begin
         $error("nv_host_ctrl: wait counts out of range");
      end
   end

   // ---------------------------------------------------------------
   // Supply sense synchroniser
   // ---------------------------------------------------------------
   logic supply_ok;  // Filtered supply-good level.
   nv_sync u_sync (
      .clk_sys_in(clk_sys_in),
      .rst_n_in(rst_n_in),
      .async_in(supply_ok_in),
      .init_in(1'b0),
      .level_out(supply_ok)
   );

   // ---------------------------------------------------------------
   // State and datapath registers
   // ---------------------------------------------------------------
   nv_state_e state_q, state_d;
   logic [2:0] step_q, step_d;          // Unlock step index, 0..5.
   logic [CNT_W-1:0] cnt_q, cnt_d;      // Phase timer.
   logic is_store_q, is_store_d;        // Store rather than recall.
   logic supply_prev_q;                 // Supply level last cycle.
   mem_pins_s pins_q, pins_d;           // Registered memory strobes.
   logic done_q, done_d;
   logic refused_q, refused_d;

   // Address of one unlock step; the last step picks store or recall.
   function automatic logic [12:0] seq_addr(input logic [2:0] idx, input logic store);
      case (idx)
         3'h0: seq_addr = `NV_SEQ_A1;
         3'h1: seq_addr = `NV_SEQ_A2;
         3'h2: seq_addr = `NV_SEQ_A3;
         3'h3: seq_addr = `NV_SEQ_A4;
         3'h4: seq_addr = `NV_SEQ_A5;
         default: seq_addr = store ? `NV_SEQ_STORE : `NV_SEQ_RECALL;
      endcase
   endfunction : seq_addr

   // ---------------------------------------------------------------
   // Decoding
   // ---------------------------------------------------------------
   wire supply_rise = supply_ok & ~supply_prev_q;
   wire store_ok = store_req_in & supply_ok;
   wire store_blocked = store_req_in & ~supply_ok;
   wire start_any = store_ok | recall_req_in;
   wire cnt_zero = (cnt_q == '0);
   wire last_step = (step_q == 3'h5);
   wire [CNT_W-1:0] wait_len = is_store_q ? CNT_W'(STORE_CYC - 1) : CNT_W'(RECALL_CYC - 1);
   wire [CNT_W-1:0] ce_low_len = CNT_W'(`NV_CE_LOW_CYC - 1);
   wire [CNT_W-1:0] ce_high_len = CNT_W'(`NV_CE_HIGH_CYC - 1);

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      state_d = state_q;
      step_d = step_q;
      cnt_d = cnt_zero ? cnt_q : cnt_q - 1'b1;
      is_store_d = is_store_q;
      done_d = 1'b0;
      refused_d = 1'b0;
      // Idle pins: deselected, write high, output enable high.
      pins_d.ce_n = 1'b1;
      pins_d.oe_n = 1'b1;
      pins_d.we_n = 1'b1;
      pins_d.addr = pins_q.addr;
      case (state_q)
         ST_IDLE: begin
            if (supply_rise) begin
               state_d = ST_PWRUP;
               cnt_d = CNT_W'(RESTORE_CYC - 1);
            end else if (start_any & supply_ok) begin
               state_d = ST_CE_LOW;
               step_d = 3'h0;
               is_store_d = store_ok;
               cnt_d = ce_low_len;
               pins_d.ce_n = 1'b0;
               pins_d.addr = seq_addr(3'h0, store_ok);
            end else begin
               refused_d = store_blocked;
            end
         end
         ST_CE_LOW: begin
            pins_d.ce_n = 1'b0;
            pins_d.oe_n = 1'b0;
            if (!supply_ok) begin
               state_d = ST_IDLE;
               pins_d.ce_n = 1'b1;
               // Output enable is released with chip enable, so it never stands alone.
               pins_d.oe_n = 1'b1;
               refused_d = 1'b1;
            end else if (cnt_zero) begin
               pins_d.ce_n = 1'b1;
               pins_d.oe_n = 1'b1;
               cnt_d = last_step ? wait_len : ce_high_len;
               state_d = last_step ? ST_WAIT : ST_CE_HIGH;
            end
         end
         ST_CE_HIGH: begin
            if (cnt_zero) begin
               step_d = step_q + 3'h1;
               pins_d.addr = seq_addr(step_q + 3'h1, is_store_q);
               pins_d.ce_n = 1'b0;
               cnt_d = ce_low_len;
               state_d = ST_CE_LOW;
            end
         end
         ST_WAIT: begin
            if (cnt_zero) begin
               state_d = ST_IDLE;
               done_d = 1'b1;
            end
         end
         ST_PWRUP: begin
            if (cnt_zero) begin
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   // strobes reset inactive
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_q <= ST_IDLE;
         step_q <= 3'h0;
         cnt_q <= '0;
         is_store_q <= 1'b0;
         supply_prev_q <= 1'b0;
         pins_q <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 13'h0000};
         done_q <= 1'b0;
         refused_q <= 1'b0;
      end else begin
         state_q <= state_d;
         step_q <= step_d;
         cnt_q <= cnt_d;
         is_store_q <= is_store_d;
         supply_prev_q <= supply_ok;
         pins_q <= pins_d;
         done_q <= done_d;
         refused_q <= refused_d;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign busy_out = (state_q != ST_IDLE);
   assign done_out = done_q;
   assign refused_out = refused_q;
   assign mem_ce_n_out = pins_q.ce_n;
   assign mem_oe_n_out = pins_q.oe_n;
   assign mem_we_n_out = pins_q.we_n;
   assign mem_addr_out = pins_q.addr;

endmodule : nv_host_ctrl

/* File: verification/nv_host_ctrl_asserts.sv */
// Assertions on the store/recall controller's memory pins and its done and refused pulses.
// Assumes it is bound into nv_host_ctrl.
`timescale 1ns/1ps
`include "nv_ctrl_defines.svh"
module nv_host_ctrl_asserts #(
   parameter int unsigned RECALL_CYC = 10
) (
   input wire logic clk_sys_in,
   input wire logic rst_n_in,
   input wire logic supply_ok_in,
   input wire logic busy_out,
   input wire logic done_out,
   input wire logic refused_out,
   input wire logic mem_ce_n_out,
   input wire logic mem_oe_n_out,
   input wire logic mem_we_n_out,
   input wire logic [12:0] mem_addr_out
);
   int unsigned hi_q; // Cycles of chip enable high while busy.
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // Tail of one read: low once more, then high for two cycles.
   sequence rd_tail_s;
      !mem_ce_n_out ##1 mem_ce_n_out [*2];
   endsequence
   // Counts the quiet time that precedes each done pulse.
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hi_q <= 0;
      end else begin
         hi_q <= (busy_out && mem_ce_n_out) ? hi_q + 1 : 0;
      end
   end
   we_high_a: assert property (mem_we_n_out)
      else $error("write strobe driven low");
   idle_quiet_a: assert property (!busy_out |-> mem_ce_n_out)
      else $error("chip enabled while idle");
   read_pulse_a: assert property (supply_ok_in [*8] ##0 $fell(mem_ce_n_out) |=> rd_tail_s)
      else $error("chip enable pulse shape wrong");
   oe_with_ce_a: assert property (!mem_oe_n_out |-> !mem_ce_n_out)
      else $error("output enable low without chip enable");
   addr_hold_a: assert property (!mem_ce_n_out && !$fell(mem_ce_n_out) |-> $stable(mem_addr_out))
      else $error("address moved during read");
   first_addr_a: assert property ($rose(busy_out) && !mem_ce_n_out |-> mem_addr_out == `NV_SEQ_A1)
      else $error("sequence did not start at base");
   done_pulse_a: assert property (done_out |=> !done_out)
      else $error("done longer than one cycle");
   wait_len_a: assert property (done_out |-> hi_q >= RECALL_CYC)
      else $error("done before cycle time");
   refused_pulse_a: assert property (refused_out |=> !refused_out)
      else $error("refused longer than one cycle");
   low_supply_a: assert property (!supply_ok_in [*8] |-> mem_ce_n_out)
      else $error("reads issued on low supply");
endmodule : nv_host_ctrl_asserts
bind nv_host_ctrl nv_host_ctrl_asserts #(.RECALL_CYC(RECALL_CYC)) i_chk (.clk_sys_in(clk_sys_in),
   .rst_n_in(rst_n_in), .supply_ok_in(supply_ok_in), .busy_out(busy_out), .done_out(done_out),
   .refused_out(refused_out), .mem_ce_n_out(mem_ce_n_out), .mem_oe_n_out(mem_oe_n_out),
   .mem_we_n_out(mem_we_n_out),
   .mem_addr_out(mem_addr_out));

/* File: verification/nv_sram_model.sv */
// Behavioural model of the memory's store/recall control; no data path.
// Assumes chip-enable clocked reads from the host controller.
`timescale 1ns/1ps
`include "nv_ctrl_defines.svh"
module nv_sram_model #(
   parameter int STORE_NS = 400,
   parameter int RECALL_NS = 200
) (
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic [12:0] addr_in,
   input wire logic supply_ok_in,
   output logic [7:0] store_cnt_out,
   output logic [7:0] recall_cnt_out
);
   logic [12:0] seq [0:4] = '{`NV_SEQ_A1, `NV_SEQ_A2, `NV_SEQ_A3, `NV_SEQ_A4, `NV_SEQ_A5};
   int step = 0; // Steps of the unlock sequence seen so far.
   logic dirty = 1'b0; // Set by writes, cleared by store and recall.
   logic pend = 1'b0; // Recall latched on low supply.
   initial begin
      store_cnt_out = 8'h00;
      recall_cnt_out = 8'h00;
   end
   // reads clock steps; output enable ignored
   always @(posedge ce_n_in) begin
      if (!we_n_in) begin
         dirty = 1'b1;
         step = 0;
      end else if (step == 5) begin
         step = 0;
         if (addr_in == `NV_SEQ_STORE && supply_ok_in) begin
            store_cnt_out++;
            dirty = 1'b0;
            #(STORE_NS);
         end else if (addr_in == `NV_SEQ_RECALL) begin
            recall_cnt_out++;
            dirty = 1'b0;
            #(RECALL_NS);
         end
      end else if (addr_in == seq[step]) begin
         step++;
      end else begin
         step = (addr_in == `NV_SEQ_A1) ? 1 : 0;
      end
   end
   // auto store if dirty, latch recall
   always @(negedge supply_ok_in) begin
      if (dirty) store_cnt_out++;
      dirty = 1'b0;
      pend = 1'b1;
   end
   always @(posedge supply_ok_in) pend = 1'b0;
endmodule : nv_sram_model

/* File: verification/test_nv_store_recall_control.sv */
// Self-checking bench: controller against the memory model.
// Assumes shortened store, recall and power-up waits.
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module test_nv_store_recall_control;
   logic clk = 1'b0, rst_n = 1'b0, store_req = 1'b0, recall_req = 1'b0, supply_ok = 1'b1;
   logic busy, done, refused, ce_n, oe_n, we_n, st_r;
   logic [12:0] addr;
   logic [7:0] n_st, n_rc;
   int errors = 0, samples_checked = 0, lat;
   nv_host_ctrl #(.STORE_CYC(20), .RECALL_CYC(10), .RESTORE_CYC(30)) i_dut (.clk_sys_in(clk),
      .rst_n_in(rst_n), .store_req_in(store_req), .recall_req_in(recall_req), .supply_ok_in(supply_ok),
      .busy_out(busy), .done_out(done), .refused_out(refused), .mem_ce_n_out(ce_n),
      .mem_oe_n_out(oe_n), .mem_we_n_out(we_n), .mem_addr_out(addr));
   nv_sram_model #(.STORE_NS(400), .RECALL_NS(200)) i_mem (.ce_n_in(ce_n), .we_n_in(we_n),
      .addr_in(addr), .supply_ok_in(supply_ok), .store_cnt_out(n_st), .recall_cnt_out(n_rc));
   initial forever #12.5 clk = ~clk;
   // Lower bound on start-to-done span: 20 cycles of reads, then the wait.
   function automatic int min_lat(input logic st);
      return 20 + (st ? 20 : 10);
   endfunction : min_lat
   task automatic test_done;
      if (errors == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : test_done
   task automatic issue(input logic st, input logic rc);
      @(posedge clk);
      store_req <= st;
      recall_req <= rc;
      @(posedge clk);
      store_req <= 1'b0;
      recall_req <= 1'b0;
   endtask : issue
   task automatic wait_end(output int n);
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (done !== 1'b1 && refused !== 1'b1 && n < 200);
   endtask : wait_end
   // One command, with a stray recall while busy that must be ignored.
   task automatic op(input logic st, input logic rc);
      logic [7:0] s0;
      logic [7:0] r0;
      s0 = n_st;
      r0 = n_rc;
      repeat ($urandom % 5) @(posedge clk);
      issue(st, rc);
      issue(1'b0, 1'b1);
      wait_end(lat);
      `CHK(lat >= min_lat(st), 1'b1)
      `CHK(done, 1'b1)
      repeat (40) @(negedge clk);
      `CHK(n_st, s0 + st)
      `CHK(n_rc, r0 + (rc & ~st))
   endtask : op
   // Supply loss before a request, or in the middle of its reads.
   task automatic supply_drop(input logic mid);
      logic [7:0] s0;
      s0 = n_st;
      if (mid) begin
         issue(1'b1, 1'b0);
         repeat (8) @(posedge clk);
         supply_ok <= 1'b0;
      end else begin
         supply_ok <= 1'b0;
         repeat (12) @(posedge clk);
         issue(1'b1, 1'b0);
      end
      wait_end(lat);
      `CHK(refused, 1'b1)
      repeat (12) @(posedge clk);
      supply_ok <= 1'b1;
      repeat (60) @(posedge clk);
      `CHK(n_st, s0)
   endtask : supply_drop
   initial begin
      void'($urandom(32'hf9af));
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (60) @(posedge clk);
      op(1'b1, 1'b1);
      op(1'b0, 1'b1);
      supply_drop(1'b0);
      supply_drop(1'b1);
      op(1'b1, 1'b0);
      repeat (6) begin
         st_r = 1'($urandom % 2);
         op(st_r, ~st_r | 1'($urandom % 2));
      end
      test_done();
   end
   initial begin
      #(25 * 20000);
      errors++;
      test_done();
   end
endmodule : test_nv_store_recall_control
